//--- dcu_pkg.sv
// Shared constants for the debug command unit.
package dcu_pkg;
   // -----------------------------------------------------------------
   // Command codes
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_PRD = 8'h0B;
   localparam logic [7:0] CMD_DWR = 8'h0C;
   localparam logic [7:0] CMD_DRD = 8'h0D;
   localparam logic [7:0] CMD_CRC = 8'h0E;
   localparam logic [7:0] CMD_STEP = 8'h10;
   localparam logic [7:0] CMD_STUFF = 8'h11;
   localparam logic [7:0] CMD_EXEC = 8'h12;
   localparam logic [7:0] CMD_WWR = 8'h20;
   localparam logic [7:0] CMD_WRD = 8'h21;
   // -----------------------------------------------------------------
   // Field positions, masks and reset values
   // -----------------------------------------------------------------
   localparam int CTL_HALT = 7;
   localparam int CTL_BREAKPOINT_ENABLE_BIT = 6;
   localparam int CTL_ACKEN = 5;
   localparam int CTL_CHIPRST = 0;
   localparam logic [7:0] CTL_MASK = 8'hE1;
   localparam int WC_WRITE = 7;
   localparam int WC_READ = 6;
   localparam int WC_DMATCH = 5;
   localparam logic [7:0] WC_MASK = 8'hEF;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] WC_RESET = 8'h00;
   localparam logic [7:0] WA_RESET = 8'h00;
   localparam logic [7:0] WD_RESET = 8'h00;
   localparam logic [7:0] STAT_RESET = 8'h00;
   // -----------------------------------------------------------------
   // Data values
   // -----------------------------------------------------------------
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   localparam logic [7:0] ACK_BYTE = 8'hFF;
   localparam logic [7:0] BRK_OPCODE = 8'h00;
   localparam logic [15:0] CRC_BLOCKED = 16'hFFFF;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam int TX_DEPTH = 32;
   localparam int PROG_BYTES = 65536;
endpackage

//--- debug_command_unit.sv
// Debug command unit with its transmit FIFO.
//
// Contract
// R1: Program read takes address then size, high bytes first; size zero means 65536.
// R2: Program read outside debug mode or under protection returns FFH per byte.
// R3: Data write takes address, size, bytes; discarded outside debug or under protection.
// R4: Data read framed like write; returns FFH only outside debug mode.
// R5: CRC command returns CCITT CRC of program memory, high first; FFFFH outside debug.
// R6: CRC answer comes after reading all program memory, one byte per read.
// R7: Step runs one instruction; ignored outside debug or under protection.
// R8: Stuff takes one opcode byte for the CPU; ignored when not allowed.
// R9: Execute takes 1-5 bytes by opcode length; one byte discarded when not allowed.
// R10: Watch write takes control, address, data; control cleared when not allowed.
// R11: Watch read returns control, address, match data in that order.
// R12: Host writes 81H reset-stop, 41H reset-go, 40H resume.
// R13: Control bit 7 stops the CPU; clearing it lets the CPU run.
// R14: Enabled breakpoint or watch break sets control bit 7 by itself.
// R15: Under protection writes never clear control bit 7.
// R16: Breakpoint enable bit 6 resets to 0; breakpoint opcode then acts as no-op.
// R17: With bit 5 set, each break sends FFH to the host.
// R18: Bit 0 resets the chip but not this unit; clears when reset completes.
// R19: Status shows debug bit 7, halt bit 6, protection bit 5, rest zero.
// R20: Watch control bits 7 and 6 break on writes and reads; none settable protected.
// R21: Data-match bit 5 requires equal data, only when a read or write break is enabled.
// R22: Watch compares 12-bit address from control bits 3:0 and the address register.
// R23: Reserved control bits read zero and writes to them are ignored.
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------
// Byte FIFO between the command engine and the host link
// ---------------------------------------------------------------------
module dcu_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic sys_clk,  // System clock.
   input wire logic arst_n,  // Asynchronous reset, active low.
   input wire logic in_valid,  // Write side offers a word.
   input wire logic [WIDTH-1:0] in_data,  // Word offered.
   output logic in_ready,  // FIFO has room.
   output logic out_valid,  // FIFO holds a word.
   output logic [WIDTH-1:0] out_data,  // Oldest word.
   input wire logic out_ready  // Drain side takes the word.
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } fifo_t;
   fifo_t q, d;
   logic full, empty;

   // Pointers carry one extra wrap bit so full and empty are exact.
   assign empty = (q.wp == q.rp);
   assign full = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = q.mem[q.rp[AW-1:0]];

   // Next state.
   always_comb begin
      d = q;
      if (in_valid && !full) begin
         d.mem[q.wp[AW-1:0]] = in_data;
         d.wp = q.wp + 1'b1;
      end
      if (out_ready && !empty) begin
         d.rp = q.rp + 1'b1;
      end
   end

   // State register.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// ---------------------------------------------------------------------
// Command engine, control registers and watch comparator
// ---------------------------------------------------------------------
module debug_command_unit #(
   parameter int PROG_SIZE = dcu_pkg::PROG_BYTES
) (
   input wire logic sys_clk,  // System clock, 20 MHz.
   input wire logic arst_n,  // Asynchronous reset, active low.
   input wire logic rx_valid,  // Host byte available.
   input wire logic [7:0] rx_data,  // Host byte.
   output logic rx_ready,  // Host byte taken this cycle.
   output logic tx_valid,  // Byte for the host available.
   output logic [7:0] tx_data,  // Byte for the host.
   input wire logic tx_ready,  // Link takes the byte.
   input wire logic ctl_wr,  // Control register write strobe.
   input wire logic [7:0] ctl_wdata,  // Control register write data.
   output logic [7:0] debug_control,  // Control register value.
   output logic [7:0] debug_status,  // Status register value.
   input wire logic protect_active_flag,  // Read protection enabled.
   input wire logic cpu_halted,  // CPU is in halt mode.
   output logic halt_for_debug_bit,  // CPU must stop fetching.
   input wire logic dec_valid,  // CPU decoded an opcode.
   input wire logic [7:0] dec_opcode,  // Decoded opcode.
   output logic step_pulse,  // Run one instruction.
   output logic stuff_pulse,  // Run one instruction with stuffed opcode.
   output logic exec_pulse,  // One execute instruction byte.
   output logic [7:0] exec_byte,  // Stuffed or executed byte.
   input wire logic [2:0] instr_len,  // Length of opcode on rx_data.
   output logic chip_reset_req,  // Reset the rest of the chip.
   input wire logic chip_reset_done,  // Chip reset finished.
   input wire logic rf_access,  // Register-file access.
   input wire logic rf_write,  // Access is a write.
   input wire logic [11:0] rf_addr,  // Register-file address.
   input wire logic [7:0] rf_data,  // Register-file data.
   output logic mem_req,  // Memory access request.
   output logic mem_we,  // Request is a write.
   output logic mem_prog,  // Program memory when high.
   output logic [15:0] mem_addr,  // Memory byte address.
   output logic [7:0] mem_wdata,  // Memory write data.
   input wire logic mem_ack,  // Access done, read data valid.
   input wire logic [7:0] mem_rdata  // Memory read data.
);
   typedef enum logic [4:0] {
      IDLE, ADR_H, ADR_L, SZ_H, SZ_L, RD_GO, RD_WAIT, WR_DAT, WR_WAIT,
      CRC_RD, CRC_HI, CRC_LO, STUFF_OP, EX_FIRST, EX_REST,
      W_CTL, W_ADR, W_DAT, W_TX
   } st_t;
   typedef struct packed {
      st_t st;
      logic [7:0] cmd;
      logic [15:0] addr;
      logic [16:0] cnt;
      logic blk;
      logic [7:0] ctl;
      logic [7:0] stat;
      logic [7:0] wc;
      logic [7:0] wa;
      logic [7:0] wd;
      logic [15:0] crc;
      logic [7:0] txd;
      logic txv;
      logic ack_pend;
      logic [2:0] xlen;
      logic [1:0] widx;
      logic mreq;
      logic mwe;
      logic mprog;
      logic [7:0] mwd;
      logic step;
      logic stuff;
      logic xstb;
      logic [7:0] xbyte;
   } state_t;
   localparam logic [16:0] PROG_CNT = 17'(PROG_SIZE);
   state_t q, d;
   logic fifo_in_ready, dbg, allow, watch_hit, brk_hit, last;

   // CCITT update over one byte, most significant bit first.
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ((r << 1) ^ dcu_pkg::CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   // Outputs straight from the state register.
   assign debug_control = q.ctl;
   assign debug_status = q.stat;
   assign halt_for_debug_bit = q.ctl[dcu_pkg::CTL_HALT];  // R13
   assign chip_reset_req = q.ctl[dcu_pkg::CTL_CHIPRST];
   assign step_pulse = q.step;
   assign stuff_pulse = q.stuff;
   assign exec_pulse = q.xstb;
   assign exec_byte = q.xbyte;
   assign mem_req = q.mreq;
   assign mem_we = q.mwe;
   assign mem_prog = q.mprog;
   assign mem_addr = q.addr;
   assign mem_wdata = q.mwd;
   assign dbg = q.ctl[dcu_pkg::CTL_HALT];
   assign allow = dbg && !protect_active_flag;
   assign last = (q.cnt == 17'h00001);

   // Watch comparator; data match only narrows an enabled break.
   always_comb begin
      watch_hit = rf_access && (rf_addr == {q.wc[3:0], q.wa})  // R22
         && ((rf_write && q.wc[dcu_pkg::WC_WRITE])  // R20
         || (!rf_write && q.wc[dcu_pkg::WC_READ]))  // R20
         && (!q.wc[dcu_pkg::WC_DMATCH] || (rf_data == q.wd));  // R21
   end

   // A break only counts while the CPU is still running.
   assign brk_hit = !dbg && (watch_hit || (dec_valid  // R14
      && (dec_opcode == dcu_pkg::BRK_OPCODE) && q.ctl[dcu_pkg::CTL_BREAKPOINT_ENABLE_BIT]));  // R16

   // Only idle and byte-consuming states take host bytes.
   always_comb begin
      case (q.st)
         IDLE: rx_ready = !q.txv && !q.ack_pend;
         ADR_H, ADR_L, SZ_H, SZ_L, STUFF_OP, EX_FIRST, EX_REST: rx_ready = 1'b1;
         W_CTL, W_ADR, W_DAT: rx_ready = 1'b1;
         WR_DAT: rx_ready = 1'b1;
         default: rx_ready = 1'b0;
      endcase
   end

   // Next state: registers, then the command sequencer.
   always_comb begin
      d = q;
      d.step = 1'b0;
      d.stuff = 1'b0;
      d.xstb = 1'b0;
      if (q.txv && fifo_in_ready) begin
         d.txv = 1'b0;
      end
      d.stat = {dbg, cpu_halted, protect_active_flag, 5'h00};  // R19
      // Control write; protection keeps the halt bit set.
      if (ctl_wr) begin
         d.ctl = ctl_wdata & dcu_pkg::CTL_MASK;  // R23
         if (protect_active_flag && dbg) begin
            d.ctl[dcu_pkg::CTL_HALT] = 1'b1;  // R15
         end
      end
      // The chip reset request drops when the chip reports completion.
      if (q.ctl[dcu_pkg::CTL_CHIPRST] && chip_reset_done && !ctl_wr) begin
         d.ctl[dcu_pkg::CTL_CHIPRST] = 1'b0;  // R18
      end
      // A break beats a clearing write in the same cycle.
      if (brk_hit) begin
         d.ctl[dcu_pkg::CTL_HALT] = 1'b1;  // R14
         if (q.ctl[dcu_pkg::CTL_ACKEN]) begin
            d.ack_pend = 1'b1;  // R17
         end
      end
      case (q.st)
         IDLE: begin
            if (q.ack_pend && !q.txv) begin
               d.txd = dcu_pkg::ACK_BYTE;  // R17
               d.txv = 1'b1;
               d.ack_pend = brk_hit && q.ctl[dcu_pkg::CTL_ACKEN];
            end else if (rx_valid && rx_ready) begin
               d.cmd = rx_data;
               case (rx_data)
                  dcu_pkg::CMD_PRD, dcu_pkg::CMD_DWR, dcu_pkg::CMD_DRD: d.st = ADR_H;
                  dcu_pkg::CMD_CRC: begin
                     d.addr = 16'h0000;
                     if (dbg) begin
                        d.cnt = PROG_CNT;  // R6
                        d.crc = dcu_pkg::CRC_INIT;
                        d.mreq = 1'b1;
                        d.mwe = 1'b0;
                        d.mprog = 1'b1;
                        d.st = CRC_RD;
                     end else begin
                        d.crc = dcu_pkg::CRC_BLOCKED;  // R5
                        d.st = CRC_HI;
                     end
                  end
                  dcu_pkg::CMD_STEP: d.step = allow;  // R7
                  dcu_pkg::CMD_STUFF: d.st = STUFF_OP;
                  dcu_pkg::CMD_EXEC: d.st = EX_FIRST;
                  dcu_pkg::CMD_WWR: d.st = W_CTL;
                  dcu_pkg::CMD_WRD: begin
                     d.widx = 2'd0;
                     d.st = W_TX;
                  end
                  default: d.st = IDLE;
               endcase
            end
         end
         // Address and size arrive high byte first.
         ADR_H: if (rx_valid) begin
            d.addr[15:8] = rx_data;  // R1
            d.st = ADR_L;
         end
         ADR_L: if (rx_valid) begin
            d.addr[7:0] = rx_data;
            d.st = SZ_H;
         end
         SZ_H: if (rx_valid) begin
            d.cnt[15:8] = rx_data;
            d.st = SZ_L;
         end
         SZ_L: if (rx_valid) begin
            d.cnt = {(q.cnt[15:8] == 8'h00) && (rx_data == 8'h00), q.cnt[15:8], rx_data};  // R1
            if (q.cmd == dcu_pkg::CMD_DRD) begin
               d.blk = !dbg;  // R4
            end else begin
               d.blk = !allow;  // R2 R3
            end
            d.st = (q.cmd == dcu_pkg::CMD_DWR) ? WR_DAT : RD_GO;
         end
         // Reads: one byte at a time, held back while the FIFO is full.
         RD_GO: if (!q.txv) begin
            if (q.blk) begin
               d.txd = dcu_pkg::FILL_BYTE;  // R2 R4
               d.txv = 1'b1;
               d.addr = q.addr + 16'h0001;
               d.cnt = q.cnt - 17'h00001;
               d.st = last ? IDLE : RD_GO;
            end else begin
               d.mreq = 1'b1;
               d.mwe = 1'b0;
               d.mprog = (q.cmd == dcu_pkg::CMD_PRD);
               d.st = RD_WAIT;
            end
         end
         RD_WAIT: if (mem_ack) begin
            d.mreq = 1'b0;
            d.txd = mem_rdata;
            d.txv = 1'b1;
            d.addr = q.addr + 16'h0001;
            d.cnt = q.cnt - 17'h00001;
            d.st = last ? IDLE : RD_GO;
         end
         // Writes: a blocked byte is consumed and dropped.
         WR_DAT: if (rx_valid) begin
            if (q.blk) begin
               d.addr = q.addr + 16'h0001;  // R3
               d.cnt = q.cnt - 17'h00001;
               d.st = last ? IDLE : WR_DAT;
            end else begin
               d.mreq = 1'b1;
               d.mwe = 1'b1;
               d.mprog = 1'b0;
               d.mwd = rx_data;
               d.st = WR_WAIT;
            end
         end
         WR_WAIT: if (mem_ack) begin
            d.mreq = 1'b0;
            d.mwe = 1'b0;
            d.addr = q.addr + 16'h0001;
            d.cnt = q.cnt - 17'h00001;
            d.st = last ? IDLE : WR_DAT;
         end
         // The request stays up; each acknowledge folds one byte in.
         CRC_RD: if (mem_ack) begin
            d.crc = crc_byte(q.crc, mem_rdata);  // R5
            d.addr = q.addr + 16'h0001;
            d.cnt = q.cnt - 17'h00001;
            if (last) begin
               d.mreq = 1'b0;
               d.st = CRC_HI;  // R6
            end
         end
         CRC_HI: if (!q.txv) begin
            d.txd = q.crc[15:8];  // R5
            d.txv = 1'b1;
            d.st = CRC_LO;
         end
         CRC_LO: if (!q.txv) begin
            d.txd = q.crc[7:0];
            d.txv = 1'b1;
            d.st = IDLE;
         end
         STUFF_OP: if (rx_valid) begin
            d.stuff = allow;  // R8
            d.xbyte = rx_data;
            d.st = IDLE;
         end
         // Execute length comes from the CPU decoder on the first byte.
         EX_FIRST: if (rx_valid) begin
            d.xstb = allow;  // R9
            d.xbyte = rx_data;
            d.xlen = instr_len - 3'd1;
            d.st = (allow && instr_len > 3'd1) ? EX_REST : IDLE;  // R9
         end
         EX_REST: if (rx_valid) begin
            d.xstb = 1'b1;
            d.xbyte = rx_data;
            d.xlen = q.xlen - 3'd1;
            d.st = (q.xlen == 3'd1) ? IDLE : EX_REST;
         end
         W_CTL: if (rx_valid) begin
            d.wc = allow ? (rx_data & dcu_pkg::WC_MASK) : 8'h00;  // R10 R20 R23
            d.st = W_ADR;
         end
         W_ADR: if (rx_valid) begin
            d.wa = rx_data;
            d.st = W_DAT;
         end
         W_DAT: if (rx_valid) begin
            d.wd = rx_data;
            d.st = IDLE;
         end
         W_TX: if (!q.txv) begin
            d.txd = (q.widx == 2'd0) ? q.wc : (q.widx == 2'd1) ? q.wa : q.wd;  // R11
            d.txv = 1'b1;
            d.widx = q.widx + 2'd1;
            d.st = (q.widx == 2'd2) ? IDLE : W_TX;
         end
         default: d.st = IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.st <= IDLE;
         q.ctl <= dcu_pkg::CTL_RESET;  // R16
         q.stat <= dcu_pkg::STAT_RESET;
         q.wc <= dcu_pkg::WC_RESET;
         q.wa <= dcu_pkg::WA_RESET;
         q.wd <= dcu_pkg::WD_RESET;
      end else begin
         q <= d;
      end
   end

   // Host bytes leave through the FIFO; a full FIFO stalls the sequencer.
   dcu_fifo #(.WIDTH(8), .DEPTH(dcu_pkg::TX_DEPTH)) u_tx (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .in_valid(q.txv),
      .in_data(q.txd),
      .in_ready(fifo_in_ready),
      .out_valid(tx_valid),
      .out_data(tx_data),
      .out_ready(tx_ready)
   );

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence brk_seen;
      dec_valid && dec_opcode == dcu_pkg::BRK_OPCODE && !dbg && !ctl_wr;
   endsequence
   sequence blocked_read;
      q.st == RD_GO && q.blk && !q.txv;
   endsequence

   chk_halt_write: assert property (ctl_wr && ctl_wdata[7] |=> halt_for_debug_bit)  // R13
      else $error("halt bit not set by write");
   chk_brk_entry: assert property (brk_seen ##0 q.ctl[6] |=> halt_for_debug_bit)  // R14
      else $error("breakpoint did not stop cpu");
   chk_brk_nop: assert property (brk_seen ##0 !q.ctl[6] && !watch_hit |=> !halt_for_debug_bit)  // R16
      else $error("disabled breakpoint stopped cpu");
   chk_protect_hold: assert property (protect_active_flag && dbg |=> dbg)  // R15
      else $error("halt bit cleared under protection");
   chk_status_bits: assert property (1'b1 |=> debug_status == {$past(dbg), $past(cpu_halted), $past(protect_active_flag), 5'h00})  // R19
      else $error("status register wrong");
   chk_fill_byte: assert property (blocked_read |=> q.txv && q.txd == 8'hFF ##1 q.st != RD_WAIT)  // R2
      else $error("blocked read did not fill");
   chk_wctl_clear: assert property (q.st == W_CTL && rx_valid && !allow |=> q.wc == 8'h00)  // R10
      else $error("watch control not cleared");
   chk_crc_blocked: assert property (q.st == IDLE && rx_valid && rx_ready && rx_data == 8'h0E && !dbg |=> q.crc == 16'hFFFF ##1 q.txd == 8'hFF [*1])  // R5
      else $error("crc not blocked");
   chk_step_gate: assert property (q.st == IDLE && rx_valid && rx_ready && rx_data == 8'h10 |=> step_pulse == $past(allow))  // R7
      else $error("step gating wrong");
   chk_rst_clear: assert property (chip_reset_req && chip_reset_done && !ctl_wr |=> !chip_reset_req)  // R18
      else $error("chip reset bit stuck");
   chk_ack_pend: assert property (brk_hit && q.ctl[5] |=> q.ack_pend [*1] ##[0:40] (q.txv && q.txd == 8'hFF))  // R17
      else $error("break ack not sent");
endmodule

`default_nettype wire

//--- mem_model.sv
// Memory responder standing behind the debug unit's memory port.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input wire logic sys_clk,  // System clock.
   input wire logic mem_req,  // Access request.
   input wire logic [15:0] mem_addr,  // Byte address.
   output var logic mem_ack,  // One-cycle completion.
   output logic [7:0] mem_rdata  // Data, valid with the acknowledge.
);
   logic [1:0] wait_q = 2'h0;
   logic [7:0] junk_q = 8'h00;
   // Answer on the third cycle of each request, so the unit must really wait.
   always_ff @(posedge sys_clk) begin
      junk_q <= junk_q + 8'h3B;
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      if (mem_req && !mem_ack) begin
         wait_q <= wait_q + 2'h1;
         mem_ack <= (wait_q == 2'h1);
      end
   end
   // Outside an acknowledge the bus moves, so stale data is never mistaken for an answer.
   assign mem_rdata = mem_ack ? (mem_addr[7:0] ^ 8'h5A) : junk_q;
endmodule
`default_nettype wire

//--- test_debug_command_unit.sv
// Self-checking bench for the debug command unit.
`timescale 1ns/1ps
`default_nettype none
module test_debug_command_unit;
   logic sys_clk = 1'b0, arst_n = 1'b0, rx_valid = 1'b0, tx_ready = 1'b0, ctl_wr = 1'b0;
   logic protect_active_flag = 1'b0, cpu_halted = 1'b0, dec_valid = 1'b0;
   logic chip_reset_done = 1'b0, rf_access = 1'b0, rf_write = 1'b0;
   logic [7:0] rx_data = 8'h00, ctl_wdata = 8'h00, dec_opcode = 8'h00, rf_data = 8'h00;
   logic [11:0] rf_addr = 12'h000;
   logic [2:0] instr_len = 3'h1;
   logic rx_ready, tx_valid, halt_for_debug_bit, step_pulse, stuff_pulse, exec_pulse;
   logic chip_reset_req, mem_req, mem_we, mem_prog, mem_ack;
   logic [7:0] tx_data, debug_control, debug_status, exec_byte, mem_wdata, mem_rdata;
   logic [15:0] mem_addr;
   int err_total = 0, n_checks = 0, cyc_cnt = 0, n_step = 0, n_stuff = 0, n_exec = 0;

   debug_command_unit #(.PROG_SIZE(16)) DUT (.sys_clk, .arst_n, .rx_valid, .rx_data,
      .rx_ready, .tx_valid, .tx_data, .tx_ready, .ctl_wr, .ctl_wdata, .debug_control,
      .debug_status, .protect_active_flag, .cpu_halted, .halt_for_debug_bit, .dec_valid,
      .dec_opcode, .step_pulse, .stuff_pulse, .exec_pulse, .exec_byte, .instr_len,
      .chip_reset_req, .chip_reset_done, .rf_access, .rf_write, .rf_addr, .rf_data,
      .mem_req, .mem_we, .mem_prog, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
   mem_model mem (.sys_clk, .mem_req, .mem_addr, .mem_ack, .mem_rdata);

   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   // -----------------------------------------------------------------
   // Host side and CPU side tasks
   // -----------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Bytes go back to back with valid held high, so valid never toggles within a step.
   task automatic send(input logic [7:0] b[$]);
      int k;
      rx_valid = 1'b1;
      foreach (b[j]) begin
         rx_data = b[j];
         @(negedge sys_clk);
         for (k = 0; k < 100 && rx_ready !== 1'b1; k++) @(negedge sys_clk);
         cyc(1);
      end
      rx_valid = 1'b0;
      cyc(1);
   endtask
   task automatic get(input logic [7:0] exp);
      int k;
      for (k = 0; k < 400 && tx_valid !== 1'b1; k++) cyc(1);
      chk("reply valid", {15'h0000, tx_valid}, 16'h0001);
      chk("reply byte", {8'h00, tx_data}, {8'h00, exp});
      tx_ready = 1'b1;
      cyc(1);
      tx_ready = 1'b0;
      cyc(1);
   endtask
   task automatic wctl(input logic [7:0] v, input logic [7:0] exp);
      ctl_wr = 1'b1;
      ctl_wdata = v;
      cyc(1);
      ctl_wr = 1'b0;
      cyc(1);
      chk("debug_control", {8'h00, debug_control}, {8'h00, exp});
   endtask
   // One register-file write or one decoded opcode, then the break outcome settles.
   task automatic event_in(input logic rf, input logic [11:0] a, input logic [7:0] d);
      rf_access = rf;
      rf_write = rf;
      dec_valid = !rf;
      rf_addr = a;
      rf_data = d;
      dec_opcode = d;
      cyc(1);
      rf_access = 1'b0;
      dec_valid = 1'b0;
      cyc(3);
   endtask

   always @(posedge sys_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 6000) begin
         err_total++;
         wrap_up();
      end
   end
   // Command pulses last one cycle, so they are counted rather than looked at.
   always @(negedge sys_clk) begin
      if (step_pulse) n_step++;
      if (stuff_pulse) n_stuff++;
      if (exec_pulse) n_exec++;
   end
   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   initial begin
      cyc(20);
      arst_n = 1'b1;
      cyc(1);
      chk("control reset", {8'h00, debug_control}, {8'h00, dcu_pkg::CTL_RESET});
      chk("status reset", {8'h00, debug_status}, {8'h00, dcu_pkg::STAT_RESET});
      // Outside debug mode program reads and CRC answer with the fill value; watch writes clear the control byte.
      send('{dcu_pkg::CMD_PRD, 8'h00, 8'h10, 8'h00, 8'h02});
      repeat (2) get(dcu_pkg::FILL_BYTE);
      send('{dcu_pkg::CMD_CRC});
      get(dcu_pkg::CRC_BLOCKED[15:8]);
      get(dcu_pkg::CRC_BLOCKED[7:0]);
      send('{dcu_pkg::CMD_WWR, 8'hA3, 8'h45, 8'h77});
      send('{dcu_pkg::CMD_WRD});
      get(8'h00);
      get(8'h45);
      get(8'h77);
      // Reset-and-stop, then the chip reset completes.
      wctl(8'h81, 8'h81);
      chk("chip reset request", {15'h0000, chip_reset_req}, 16'h0001);
      chip_reset_done = 1'b1;
      cyc(1);
      chip_reset_done = 1'b0;
      cyc(1);
      chk("control after reset", {8'h00, debug_control}, 16'h0080);
      chk("halt", {15'h0000, halt_for_debug_bit}, 16'h0001);
      chk("status debug", {8'h00, debug_status}, 16'h0080);
      send('{dcu_pkg::CMD_PRD, 8'h00, 8'h10, 8'h00, 8'h02});
      get(8'h4A);
      get(8'h4B);
      // Protection blocks program reads and clearing of the halt bit, but not data reads.
      protect_active_flag = 1'b1;
      cyc(2);
      chk("status protect", {8'h00, debug_status}, 16'h00A0);
      send('{dcu_pkg::CMD_DRD, 8'h00, 8'h20, 8'h00, 8'h01});
      get(8'h7A);
      send('{dcu_pkg::CMD_PRD, 8'h00, 8'h00, 8'h00, 8'h01});
      get(dcu_pkg::FILL_BYTE);
      wctl(8'h40, 8'hC0);
      protect_active_flag = 1'b0;
      wctl(8'h9E, 8'h80);
      send('{dcu_pkg::CMD_WWR, 8'hB3, 8'h45, 8'h77});
      send('{dcu_pkg::CMD_WRD});
      get(8'hA3);
      get(8'h45);
      get(8'h77);
      // Resume with acknowledge enabled, then exercise the watch comparator.
      wctl(8'h60, 8'h60);
      event_in(1'b1, 12'h345, 8'h76);
      chk("no break on data miss", {15'h0000, halt_for_debug_bit}, 16'h0000);
      event_in(1'b1, 12'h245, 8'h77);
      chk("no break on address miss", {15'h0000, halt_for_debug_bit}, 16'h0000);
      event_in(1'b1, 12'h345, 8'h77);
      chk("watch break", {15'h0000, halt_for_debug_bit}, 16'h0001);
      get(dcu_pkg::ACK_BYTE);
      // Breakpoint opcode is a no-op until enabled.
      wctl(8'h20, 8'h20);
      event_in(1'b0, 12'h000, dcu_pkg::BRK_OPCODE);
      chk("breakpoint disabled", {15'h0000, halt_for_debug_bit}, 16'h0000);
      wctl(8'h60, 8'h60);
      event_in(1'b0, 12'h000, dcu_pkg::BRK_OPCODE);
      chk("breakpoint", {8'h00, debug_control}, 16'h00E0);
      get(dcu_pkg::ACK_BYTE);
      // Step, execute and stuff while allowed, then each refused under protection.
      instr_len = 3'h3;
      send('{dcu_pkg::CMD_STEP, dcu_pkg::CMD_EXEC, 8'hA1, 8'hB2, 8'hC3});
      chk("exec byte", {8'h00, exec_byte}, 16'h00C3);
      send('{dcu_pkg::CMD_STUFF, 8'h5E});
      chk("stuff byte", {8'h00, exec_byte}, 16'h005E);
      protect_active_flag = 1'b1;
      send('{dcu_pkg::CMD_STEP, dcu_pkg::CMD_STUFF, 8'h11, dcu_pkg::CMD_EXEC, 8'h12,
         dcu_pkg::CMD_WRD});
      get(8'hA3);
      chk("pulse counts", 16'({n_step[3:0], n_stuff[3:0], n_exec[3:0]}), 16'h0113);
      wrap_up();
   end
endmodule
`default_nettype wire
